// *** design/rdcs_pkg.sv ***
package rdcs_pkg;
	// ==================================================
	// register byte addresses (printed offsets are not all multiples of four)
	localparam logic [7:0] RDCS_IDX_EDGE = 8'h0b;
	localparam logic [7:0] RDCS_IDX_CONT = 8'h0d;
	localparam logic [7:0] RDCS_IDX_SWING = 8'h0e;
	localparam logic [7:0] RDCS_IDX_IRQ_STAT = 8'h20;
	localparam logic [7:0] RDCS_IDX_IRQ_MASK = 8'h21;
	localparam logic [11:0] RDCS_ADDR_EDGE = {2'h0, RDCS_IDX_EDGE, 2'h0};
	localparam logic [11:0] RDCS_ADDR_CONT = {2'h0, RDCS_IDX_CONT, 2'h0};
	localparam logic [11:0] RDCS_ADDR_SWING = {2'h0, RDCS_IDX_SWING, 2'h0};
	localparam logic [11:0] RDCS_ADDR_IRQ_STAT = {2'h0, RDCS_IDX_IRQ_STAT, 2'h0};
	localparam logic [11:0] RDCS_ADDR_IRQ_MASK = {2'h0, RDCS_IDX_IRQ_MASK, 2'h0};
	// ==================================================
	// field positions
	localparam int RDCS_POS_LANE3 = 6;
	localparam int RDCS_POS_LANE2 = 4;
	localparam int RDCS_POS_LANE1 = 2;
	localparam int RDCS_POS_LANE0 = 0;
	localparam int RDCS_POS_SWING = 4;
	localparam int RDCS_POS_PRE = 0;
	localparam int RDCS_POS_OUT_NEG = 5;
	localparam int RDCS_POS_OUT_POS = 4;
	localparam int RDCS_POS_IN_NEG = 1;
	localparam int RDCS_POS_IN_POS = 0;
	localparam logic [7:0] RDCS_MASK_SWING = 8'h33;
	localparam logic [7:0] RDCS_MASK_CONT = 8'h33;
	// ==================================================
	// reset values and codes
	localparam logic [7:0] RDCS_RST_EDGE = 8'h00;
	localparam logic [7:0] RDCS_RST_CONT = 8'h00;
	localparam logic [7:0] RDCS_RST_SWING = 8'h00;
	localparam logic [7:0] RDCS_RST_IRQ = 8'h00;
	localparam logic [1:0] RDCS_CODE_00 = 2'h0;
	localparam logic [1:0] RDCS_CODE_01 = 2'h1;
	localparam logic [1:0] RDCS_CODE_10 = 2'h2;
	localparam int RDCS_SYNC_STAGES = 3;
	// three-level strap pin
	typedef enum logic [1:0] {
		RDCS_LVL_LOW,
		RDCS_LVL_MID,
		RDCS_LVL_HIGH
	} rdcs_level_type;
endpackage

// *** design/rdcs_sync.sv ***
`timescale 1ns/1ns
// ==================================================
// three-stage synchroniser, change accepted when stages two and three agree
module rdcs_sync
	import rdcs_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, q_q;
	logic [WIDTH-1:0] q_d;

	// accept a bit only once the two later stages agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q_q[i];
		end
	end

	// first stage feeds only the second stage
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			q_q <= '0;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q_q <= q_d;
		end
	end

	assign q_o = q_q;
endmodule

// *** design/rdcs_regs.sv ***
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
// Notes on behaviour
// RULE_01: bits 7:6 set output lane 3 edge rate
// RULE_02: bits 5:4 set output lane 2 edge rate
// RULE_03: bits 3:2 set output lane 1 edge rate
// RULE_04: bits 1:0 set output lane 0 edge rate
// RULE_05: edge rates load from strap, then writable
// RULE_06: output lane 0 pin contention status bits
// RULE_07: input lane 0 pin contention status bits
// RULE_08: bits 5:4 of tx_swing_preemph_ctrl set swing
// RULE_09: swing initialises from both strap pins
// RULE_10: bits 1:0 of tx_swing_preemph_ctrl set pre-emphasis
// RULE_11: pre-emphasis initialises from strap pin 1
// RULE_12: straps captured at reset-input rising edge
// RULE_13: reserved bits read zero, ignore writes
module rdcs_regs
	import rdcs_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_I,
	// apb slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// device reset pin and straps, each strap as {high, mid} level flags
	input wire logic RESET_N_INPUT_I,
	input wire logic [1:0] EDGE_RATE_STRAP_PIN_I,
	input wire logic [1:0] STRAP_PIN_0_I,
	input wire logic [1:0] STRAP_PIN_1_I,
	// contention detector levels: out neg, out pos, in neg, in pos
	input wire logic OUT_LANE0_NEG_CONTENTION_I,
	input wire logic OUT_LANE0_POS_CONTENTION_I,
	input wire logic IN_LANE0_NEG_CONTENTION_I,
	input wire logic IN_LANE0_POS_CONTENTION_I,
	// settings to the analog drivers
	output logic [1:0] OUT_LANE3_EDGE_RATE_O,
	output logic [1:0] OUT_LANE2_EDGE_RATE_O,
	output logic [1:0] OUT_LANE1_EDGE_RATE_O,
	output logic [1:0] OUT_LANE0_EDGE_RATE_O,
	output logic [1:0] TX_SWING_LEVEL_O,
	output logic [1:0] TX_PREEMPHASIS_LEVEL_O,
	output logic IRQ_O
);
	// ==================================================
	// synchronisers for pins
	logic [10:0] pins_raw, pins_s;

	assign pins_raw = {RESET_N_INPUT_I, EDGE_RATE_STRAP_PIN_I, STRAP_PIN_0_I, STRAP_PIN_1_I,
		OUT_LANE0_NEG_CONTENTION_I, OUT_LANE0_POS_CONTENTION_I,
		IN_LANE0_NEG_CONTENTION_I, IN_LANE0_POS_CONTENTION_I};

	rdcs_sync #(.WIDTH(11)) u_sync (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.d_i(pins_raw),
		.q_o(pins_s)
	);

	logic reset_n_input_s;
	logic [1:0] erc_s, strap_pin_0_s, strap_pin_1_s;
	logic [3:0] cont_s;

	assign reset_n_input_s = pins_s[10];
	assign erc_s = pins_s[9:8];
	assign strap_pin_0_s = pins_s[7:6];
	assign strap_pin_1_s = pins_s[5:4];
	assign cont_s = pins_s[3:0];

	// decode a strap pair into a level; high wins if both flags are set
	function automatic rdcs_level_type level_of(input logic [1:0] p);
		if (p[1]) begin
			return RDCS_LVL_HIGH;
		end else if (p[0]) begin
			return RDCS_LVL_MID;
		end
		return RDCS_LVL_LOW;
	endfunction

	// ==================================================
	// strap decode
	rdcs_level_type erc_lvl, strap_pin_0_lvl, strap_pin_1_lvl;
	logic [1:0] strap_edge, strap_swing, strap_pre;

	always_comb begin
		erc_lvl = level_of(erc_s);
		strap_pin_0_lvl = level_of(strap_pin_0_s);
		strap_pin_1_lvl = level_of(strap_pin_1_s);
		// edge rate: low 00, mid 01, high 10
		case (erc_lvl) // see RULE_05
			RDCS_LVL_LOW: strap_edge = RDCS_CODE_00;
			RDCS_LVL_MID: strap_edge = RDCS_CODE_01;
			RDCS_LVL_HIGH: strap_edge = RDCS_CODE_10;
			default: strap_edge = RDCS_CODE_00;
		endcase
		// swing: high on pin 0, or low pin 0 with high pin 1, gives 1X
		if (strap_pin_0_lvl == RDCS_LVL_HIGH ||
			(strap_pin_0_lvl == RDCS_LVL_LOW && strap_pin_1_lvl == RDCS_LVL_HIGH)) begin // see RULE_09
			strap_swing = RDCS_CODE_10;
		end else begin
			strap_swing = RDCS_CODE_01;
		end
		// pre-emphasis follows pin 1 alone
		strap_pre = (strap_pin_1_lvl == RDCS_LVL_HIGH) ? RDCS_CODE_10 : RDCS_CODE_01; // see RULE_11
	end

	// ==================================================
	// apb decode
	logic acc, wr, rd;

	assign acc = PSEL_I && PENABLE_I;
	assign wr = acc && PWRITE_I && PSTRB_I[0];
	assign rd = acc && !PWRITE_I;
	// zero wait states: every access completes in its first access cycle
	assign PREADY_O = 1'b1;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
		return a == r;
	endfunction

	logic mapped;

	assign mapped = hit(PADDR_I, RDCS_ADDR_EDGE) || hit(PADDR_I, RDCS_ADDR_CONT) ||
		hit(PADDR_I, RDCS_ADDR_SWING) || hit(PADDR_I, RDCS_ADDR_IRQ_STAT) ||
		hit(PADDR_I, RDCS_ADDR_IRQ_MASK);
	// unmapped addresses answer with an error and read zero
	assign PSLVERR_O = acc && !mapped;

	// ==================================================
	// configuration registers
	logic [7:0] edge_q, edge_d, swing_q, swing_d;
	logic reset_n_input_prev_q, reset_n_input_prev_d;
	logic rst_rise;

	// device reset pin release loads the straps; bus reset clears, then reloads them a few cycles later if the pin is already high
	assign rst_rise = reset_n_input_s && !reset_n_input_prev_q; // see RULE_12

	always_comb begin
		edge_d = edge_q;
		swing_d = swing_q;
		reset_n_input_prev_d = reset_n_input_s;
		if (rst_rise) begin
			edge_d = {strap_edge, strap_edge, strap_edge, strap_edge}; // see RULE_05
			swing_d = 8'h00;
			swing_d[RDCS_POS_SWING +: 2] = strap_swing; // see RULE_09
			swing_d[RDCS_POS_PRE +: 2] = strap_pre; // see RULE_11
		end else if (wr && hit(PADDR_I, RDCS_ADDR_EDGE)) begin
			edge_d = PWDATA_I[7:0]; // see RULE_05
		end else if (wr && hit(PADDR_I, RDCS_ADDR_SWING)) begin
			// reserved bits dropped on write
			swing_d = PWDATA_I[7:0] & RDCS_MASK_SWING; // see RULE_13
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			edge_q <= RDCS_RST_EDGE;
			swing_q <= RDCS_RST_SWING;
			reset_n_input_prev_q <= 1'b0;
		end else begin
			edge_q <= edge_d;
			swing_q <= swing_d;
			reset_n_input_prev_q <= reset_n_input_prev_d;
		end
	end

	// drive settings straight from the register fields
	assign OUT_LANE3_EDGE_RATE_O = edge_q[RDCS_POS_LANE3 +: 2]; // see RULE_01
	assign OUT_LANE2_EDGE_RATE_O = edge_q[RDCS_POS_LANE2 +: 2]; // see RULE_02
	assign OUT_LANE1_EDGE_RATE_O = edge_q[RDCS_POS_LANE1 +: 2]; // see RULE_03
	assign OUT_LANE0_EDGE_RATE_O = edge_q[RDCS_POS_LANE0 +: 2]; // see RULE_04
	// 1X code means the top level; the drivers decode only the upper bit then
	assign TX_SWING_LEVEL_O = swing_q[RDCS_POS_SWING +: 2]; // see RULE_08
	assign TX_PREEMPHASIS_LEVEL_O = swing_q[RDCS_POS_PRE +: 2]; // see RULE_10

	// ==================================================
	// contention status, live level of each detector
	logic [7:0] cont_q, cont_d;

	always_comb begin
		cont_d = 8'h00;
		cont_d[RDCS_POS_OUT_NEG] = cont_s[3]; // see RULE_06
		cont_d[RDCS_POS_OUT_POS] = cont_s[2]; // see RULE_06
		cont_d[RDCS_POS_IN_NEG] = cont_s[1]; // see RULE_07
		cont_d[RDCS_POS_IN_POS] = cont_s[0]; // see RULE_07
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cont_q <= RDCS_RST_CONT;
		end else begin
			cont_q <= cont_d;
		end
	end

	// ==================================================
	// interrupts: rising contention sets sticky bits, read clears
	logic [7:0] stat_q, stat_d, mask_q, mask_d, cont_rise;

	// set beats the read clear in the same cycle so no event is lost
	assign cont_rise = cont_d & ~cont_q;

	always_comb begin
		stat_d = stat_q;
		mask_d = mask_q;
		if (rd && hit(PADDR_I, RDCS_ADDR_IRQ_STAT)) begin
			stat_d = 8'h00;
		end
		stat_d = stat_d | cont_rise;
		if (wr && hit(PADDR_I, RDCS_ADDR_IRQ_MASK)) begin
			mask_d = PWDATA_I[7:0] & RDCS_MASK_CONT; // see RULE_13
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			stat_q <= RDCS_RST_IRQ;
			mask_q <= RDCS_RST_IRQ;
		end else begin
			stat_q <= stat_d;
			mask_q <= mask_d;
		end
	end

	assign IRQ_O = |(stat_q & mask_q);

	// ==================================================
	// read mux, reserved bits zero through masks
	logic [7:0] rdata;

	always_comb begin
		rdata = 8'h00;
		if (hit(PADDR_I, RDCS_ADDR_EDGE)) begin
			rdata = edge_q;
		end else if (hit(PADDR_I, RDCS_ADDR_CONT)) begin
			rdata = cont_q & RDCS_MASK_CONT; // see RULE_13
		end else if (hit(PADDR_I, RDCS_ADDR_SWING)) begin
			rdata = swing_q & RDCS_MASK_SWING; // see RULE_13
		end else if (hit(PADDR_I, RDCS_ADDR_IRQ_STAT)) begin
			rdata = stat_q;
		end else if (hit(PADDR_I, RDCS_ADDR_IRQ_MASK)) begin
			rdata = mask_q;
		end
	end

	// read data is combinational from registers; valid in the access cycle
	assign PRDATA_O = rd ? {24'h000000, rdata} : 32'h00000000;
endmodule

// *** test/rdcs_regs_checker.sv ***
`timescale 1ns/1ns
// ==================================================
// port checks of the register block
module rdcs_regs_checker
	import rdcs_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic RESET_N_INPUT_I,
	input wire logic [1:0] EDGE_RATE_STRAP_PIN_I,
	input wire logic [1:0] STRAP_PIN_0_I,
	input wire logic [1:0] STRAP_PIN_1_I,
	input wire logic [1:0] OUT_LANE3_EDGE_RATE_O,
	input wire logic [1:0] OUT_LANE2_EDGE_RATE_O,
	input wire logic [1:0] OUT_LANE1_EDGE_RATE_O,
	input wire logic [1:0] OUT_LANE0_EDGE_RATE_O,
	input wire logic [1:0] TX_SWING_LEVEL_O,
	input wire logic [1:0] TX_PREEMPHASIS_LEVEL_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	// decoded accesses; only strobe lane 0 carries the byte
	wire acc = PSEL_I & PENABLE_I;
	wire wr = acc & PWRITE_I & PSTRB_I[0];
	wire rd = acc & !PWRITE_I;
	wire e_a = PADDR_I == RDCS_ADDR_EDGE;
	wire s_a = PADDR_I == RDCS_ADDR_SWING;
	wire [7:0] edg = {OUT_LANE3_EDGE_RATE_O, OUT_LANE2_EDGE_RATE_O, OUT_LANE1_EDGE_RATE_O,
		OUT_LANE0_EDGE_RATE_O};
	wire [1:0] sw = TX_SWING_LEVEL_O;
	wire [1:0] pr = TX_PREEMPHASIS_LEVEL_O;
	// strap codes, a high flag outranks mid
	wire [1:0] ex = EDGE_RATE_STRAP_PIN_I[1] ? 2'h2 : {1'b0, EDGE_RATE_STRAP_PIN_I[0]};
	wire c1h = STRAP_PIN_1_I[1];
	wire [1:0] sx = (STRAP_PIN_0_I[1] | (STRAP_PIN_0_I == 2'h0 & c1h)) ? 2'h2 : 2'h1;
	// ==================================================
	// properties
	property p_edge; wr && e_a |=> edg == $past(PWDATA_I[7:0]); endproperty
	a_edge: assert property (p_edge) else $error("edge write");
	property p_erd; rd && e_a |-> PRDATA_O == {24'h0, edg}; endproperty
	a_erd: assert property (p_erd) else $error("edge read");
	property p_keep; (RESET_N_INPUT_I && !(wr && e_a)) [*8] |=> $stable(edg); endproperty
	a_keep: assert property (p_keep) else $error("edge drift");
	property p_sw; wr && s_a |=> sw == $past(PWDATA_I[5:4]); endproperty
	a_sw: assert property (p_sw) else $error("swing write");
	property p_pre; wr && s_a |=> pr == $past(PWDATA_I[1:0]); endproperty
	a_pre: assert property (p_pre) else $error("pre write");
	property p_srd; rd && s_a |-> PRDATA_O == {26'h0, sw, 2'h0, pr}; endproperty
	a_srd: assert property (p_srd) else $error("swing read");
	property p_crd; rd && PADDR_I == RDCS_ADDR_CONT |-> (PRDATA_O & 32'hffffffcc) == 0; endproperty
	a_crd: assert property (p_crd) else $error("status spare");
	// straps are loaded a few cycles after the pin rises
	property p_load; $rose(RESET_N_INPUT_I) ##0 (!PSEL_I) [*8] |->
		edg == {4{ex}} && sw == sx && pr == (c1h ? 2'h2 : 2'h1); endproperty
	a_load: assert property (p_load) else $error("strap load");
	c_load: cover property ($rose(RESET_N_INPUT_I));
	c_edge: cover property (wr && e_a);
	c_swing: cover property (rd && s_a && sw[1]);
endmodule
bind rdcs_regs rdcs_regs_checker u_chk (.*);

// *** test/rdcs_host.sv ***
`timescale 1ns/1ns
// ==================================================
// apb host; an idle cycle between transfers
module rdcs_host (
	input wire logic clk_i,
	output logic psel_o,
	output logic pen_o,
	output logic pwr_o,
	output logic [11:0] pa_o,
	output logic [31:0] pwd_o,
	input wire logic [31:0] prd_i,
	input wire logic prdy_i,
	input wire logic perr_i
);
	initial begin
		{psel_o, pen_o, pwr_o, pa_o, pwd_o} = '0;
	end
	// request held until pready is seen at an edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwr_o <= w;
		pa_o <= a;
		pwd_o <= d;
		@(posedge clk_i);
		pen_o <= 1'b1;
		do @(posedge clk_i); while (prdy_i !== 1'b1);
		r = prd_i;
		e = perr_i;
		{psel_o, pen_o} <= 2'h0;
	endtask
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ns
// ==================================================
// self-checking bench of the register block
module testbench;
	import rdcs_pkg::*;
	logic clk, psel, pen, pwr, perr, prdy, irq, e;
	logic rst = 1'b1;
	logic reset_n_input = 1'b0;
	logic [1:0] ers = 2'h0, s0 = 2'h0, s1 = 2'h0, sw, pr;
	logic [3:0] con = 4'h0;
	logic [7:0] el;
	logic [11:0] pa;
	logic [31:0] pwd, prd, r, d;
	int n_mismatch = 0;
	int samples_checked = 0;
	int seed = 32'h427a963f;
	rdcs_host h (.clk_i(clk), .psel_o(psel), .pen_o(pen), .pwr_o(pwr), .pa_o(pa), .pwd_o(pwd),
		.prd_i(prd), .prdy_i(prdy), .perr_i(perr));
	rdcs_regs dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(pa), .PWDATA_I(pwd), .PSTRB_I(4'hf), .PRDATA_O(prd), .PREADY_O(prdy),
		.PSLVERR_O(perr), .RESET_N_INPUT_I(reset_n_input), .EDGE_RATE_STRAP_PIN_I(ers),
		.STRAP_PIN_0_I(s0), .STRAP_PIN_1_I(s1), .OUT_LANE0_NEG_CONTENTION_I(con[3]),
		.OUT_LANE0_POS_CONTENTION_I(con[2]), .IN_LANE0_NEG_CONTENTION_I(con[1]),
		.IN_LANE0_POS_CONTENTION_I(con[0]), .OUT_LANE3_EDGE_RATE_O(el[7:6]),
		.OUT_LANE2_EDGE_RATE_O(el[5:4]), .OUT_LANE1_EDGE_RATE_O(el[3:2]),
		.OUT_LANE0_EDGE_RATE_O(el[1:0]), .TX_SWING_LEVEL_O(sw), .TX_PREEMPHASIS_LEVEL_O(pr),
		.IRQ_O(irq));
	// ==================================================
	// helpers
	function automatic logic [1:0] sx(input logic [1:0] a, b);
		return (a[1] | (a == 2'h0 & b[1])) ? 2'h2 : 2'h1;
	endfunction
	task automatic chk(input string nm, input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// the pause lets the access edge settle before looking
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		h.xfer(1'b1, a, v, r, e);
		#1;
	endtask
	task automatic rd(input logic [11:0] a);
		h.xfer(1'b0, a, 32'h0, r, e);
		#1;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// watchdog far beyond the few hundred cycles needed
	initial begin
		#80000;
		n_mismatch++;
		test_done();
	end
	// ==================================================
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(RDCS_ADDR_CONT);
		chk("cont0", r, 32'h0);
		rd(RDCS_ADDR_SWING);
		chk("swing0", r, 32'h0);
		$display("reset test done");
		// all nine pin 0 / pin 1 strap combinations, edge strap following pin 0, one pin reset each
		for (int i = 0; i < 9; i++) begin
			@(posedge clk);
			ers <= 2'(i % 3);
			s0 <= 2'(i % 3);
			s1 <= 2'(i / 3);
			reset_n_input <= 1'b0;
			repeat (4) @(posedge clk);
			reset_n_input <= 1'b1;
			repeat (10) @(posedge clk);
			rd(RDCS_ADDR_EDGE);
			chk("edge", r, {24'h0, {4{ers}}});
			rd(RDCS_ADDR_SWING);
			chk("swing", r[5:4], sx(s0, s1));
			chk("pre", r[1:0], s1[1] ? 2'h2 : 2'h1);
		end
		$display("strap test done");
		repeat (8) begin
			d = $random(seed);
			wr(RDCS_ADDR_EDGE, d);
			chk("lanes", el, d[7:0]);
			rd(RDCS_ADDR_EDGE);
			chk("edgerd", r, {24'h0, d[7:0]});
			wr(RDCS_ADDR_SWING, d);
			chk("drv", {sw, pr}, {d[5:4], d[1:0]});
			rd(RDCS_ADDR_SWING);
			chk("swrd", r, d & 32'h33);
		end
		$display("write test done");
		// status follows each detector pattern; writes are ignored
		wr(RDCS_ADDR_IRQ_MASK, 32'h1);
		wr(RDCS_ADDR_CONT, 32'hff);
		for (int i = 0; i < 17; i++) begin
			@(posedge clk);
			con <= 4'(i);
			repeat (8) @(posedge clk);
			rd(RDCS_ADDR_CONT);
			chk("cont", r, {26'h0, con[3:2], 2'h0, con[1:0]});
			chk("contin", r[1:0], con[1:0]);
		end
		rd(RDCS_ADDR_IRQ_STAT);
		chk("irqclr", irq, 1'b0);
		@(posedge clk);
		con <= 4'h2;
		repeat (8) @(posedge clk);
		chk("masked", irq, 1'b0);
		con <= 4'h3;
		repeat (8) @(posedge clk);
		chk("irq", irq, 1'b1);
		rd(RDCS_ADDR_IRQ_STAT);
		// the masked in-neg rise before is still latched beside the in-pos one
		chk("stat", r, 32'h3);
		chk("irqoff", irq, 1'b0);
		rd(12'h3fc);
		chk("unmapped", {e, r[7:0]}, 9'h100);
		$display("status test done");
		test_done();
	end
endmodule
